//--- fsr_checker.sv
`timescale 1ns/10ps
module fsr_checker (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic mosi,
    input wire logic protect_regs_lock,
    input wire logic write_enable_latch,
    input wire logic reset_cmd_enable,
    input wire logic lockdown_cmd_enable,
    input wire logic lockdown_frozen,
    input wire logic program_suspend_flag,
    input wire logic erase_suspend_flag,
    input wire logic glob_valid,
    input wire logic reset_pulse,
    input wire logic in_reset
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    // literal hold length: the bench sets RST_TIME to 4
    sequence rst_hold_s;
        in_reset[*4] ##1 !in_reset;
    endsequence
    sequence latch_drop_s;
        $fell(write_enable_latch) && cs_n;
    endsequence
    sck_idle_a: assert property (cs_n |-> !sck) else $error("sck moves outside frame");
    mosi_hold_a: assert property ((sck && $past(sck)) |-> $stable(mosi))
        else $error("mosi moved while sck high");
    lock_commit_a: assert property ($changed(protect_regs_lock) |-> glob_valid && cs_n)
        else $error("lock changed outside commit");
    wel_clear_a: assert property (glob_valid |-> !write_enable_latch)
        else $error("latch kept after write");
    enable_commit_a: assert property ($changed(reset_cmd_enable) |-> latch_drop_s)
        else $error("reset enable changed outside commit");
    reset_hold_a: assert property (reset_pulse |-> rst_hold_s)
        else $error("reset time wrong");
    reset_clear_a: assert property (reset_pulse |-> ##[0:1]
        !(write_enable_latch || program_suspend_flag || erase_suspend_flag))
        else $error("reset left flags set");
    reset_keep_a: assert property (reset_pulse |=>
        $stable(protect_regs_lock) && $stable(lockdown_cmd_enable))
        else $error("reset altered kept bits");
    reset_gate_a: assert property (reset_pulse |-> reset_cmd_enable && cs_n)
        else $error("reset ran while disabled");
    freeze_sle_a: assert property (lockdown_frozen |=> !lockdown_cmd_enable)
        else $error("lockdown enable set after freeze");
endmodule

//--- fsr_dev.sv
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/10ps
// Summary of operation
// RULE1 - host sets write latch before status writes
// RULE2 - opcode 01h, one data byte, extras dropped
// RULE3 - byte1: bit7 lock, bits5..2 global select
// RULE4 - valid byte1 write: update lock, clear latch
// RULE5 - global action uses bits5..2 and prior lock
// RULE6 - short or misaligned byte1 write aborts, clears latch
// RULE7 - protect pin: lock only settable, else ignore
// RULE8 - opcode 31h, one data byte, extras dropped
// RULE9 - byte2: bit4 reset enable, bit3 lockdown enable
// RULE10 - valid byte2 write: update enables, clear latch
// RULE11 - lockdown enable untouched once state frozen
// RULE12 - short or misaligned byte2 write aborts, clears latch
// RULE13 - reset needs no write latch
// RULE14 - reset ignored unless reset enable set
// RULE15 - reset frame F0h then D0h, extras dropped
// RULE16 - valid reset ends operations, returns idle
// RULE17 - reset keeps lock bits, clears latch, suspends
// RULE18 - short or misaligned reset frame does nothing
// RULE19 - lock powers up zero, reset keeps it
// RULE20 - reset enable powers up zero
// RULE21 - freeze forces lockdown enable zero forever
// RULE22 - incomplete opcode never clears write latch
// RULE23 - global decode lives outside, fed raw bits
// RULE24 - msb first, sampled on rising sck
module fsr_dev #(
    parameter int RST_TIME = fsr_pkg::RST_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset_n,
    fsr_if.dev link,
    input wire logic wp_n,
    input wire logic latch_set,
    input wire logic freeze_lockdown,
    input wire logic program_suspend_set,
    input wire logic erase_suspend_set,
    output logic protect_regs_lock,
    output logic write_enable_latch,
    output logic reset_cmd_enable,
    output logic lockdown_cmd_enable,
    output logic lockdown_frozen,
    output logic program_suspend_flag,
    output logic erase_suspend_flag,
    output logic glob_valid,
    output logic [3:0] glob_bits,
    output logic glob_prior_lock,
    output logic reset_pulse,
    output logic in_reset
);
    import fsr_pkg::*;

    typedef struct packed {
        logic [2:0] cs_s;
        logic [2:0] sck_s;
        logic [1:0] mosi_s;
        logic [1:0] wp_s;
        logic [7:0] shreg;
        logic [2:0] bit_cnt;
        logic [1:0] byte_cnt;
        logic [7:0] opcode;
        logic [7:0] data;
        logic lock;
        logic latch;
        logic rst_en;
        logic lkdn_en;
        logic frozen;
        logic psusp;
        logic esusp;
        logic glob_valid;
        logic [3:0] glob_bits;
        logic glob_prior;
        logic reset_pulse;
        logic [RST_W-1:0] rst_cnt;
    } fsr_dev_s;

    fsr_dev_s st;
    fsr_dev_s next_st;

    logic cs_level;
    logic cs_rise;
    logic cs_fall;
    logic sck_rise;
    logic wp_on;
    logic aligned;
    logic full_data;
    logic [7:0] shifted;

    assign cs_level = st.cs_s[1];
    assign cs_rise = st.cs_s[1] & ~st.cs_s[2];
    assign cs_fall = ~st.cs_s[1] & st.cs_s[2];
    assign sck_rise = st.sck_s[1] & ~st.sck_s[2];
    assign wp_on = ~st.wp_s[1];
    assign aligned = (st.bit_cnt == 3'h0);
    assign full_data = (st.byte_cnt == 2'h2);
    assign shifted = {st.shreg[6:0], st.mosi_s[1]};

    always_comb begin
        next_st = st;
        next_st.cs_s = {st.cs_s[1:0], link.cs_n};
        next_st.sck_s = {st.sck_s[1:0], link.sck};
        next_st.mosi_s = {st.mosi_s[0], link.mosi};
        next_st.wp_s = {st.wp_s[0], wp_n};
        next_st.glob_valid = 1'b0;
        next_st.reset_pulse = 1'b0;
        if (st.rst_cnt != '0) begin
            next_st.rst_cnt = st.rst_cnt - 1'b1;
        end
        if (cs_fall) begin
            next_st.bit_cnt = 3'h0;
            next_st.byte_cnt = 2'h0;
        end else if (!cs_level && sck_rise) begin
            next_st.shreg = shifted; // [RULE24]
            next_st.bit_cnt = st.bit_cnt + 3'h1;
            if (st.bit_cnt == 3'h7) begin
                // bytes beyond the first data byte are dropped
                if (st.byte_cnt == 2'h0) begin
                    next_st.opcode = shifted;
                end
                if (st.byte_cnt == 2'h1) begin
                    next_st.data = shifted; // [RULE2] [RULE8] [RULE15]
                end
                if (st.byte_cnt != 2'h2) begin
                    next_st.byte_cnt = st.byte_cnt + 2'h1;
                end
            end
        end
        // commands act only once the whole opcode arrived
        if (cs_rise && st.byte_cnt != 2'h0) begin // [RULE22]
            unique case (st.opcode)
                OP_WRITE_STATUS1: begin
                    if (st.latch) begin // [RULE1]
                        next_st.latch = 1'b0; // [RULE4] [RULE6]
                        if (full_data && aligned) begin // [RULE6]
                            if (!wp_on || st.data[LOCK_BIT]) begin // [RULE7]
                                next_st.lock = st.data[LOCK_BIT]; // [RULE3] [RULE4]
                                next_st.glob_valid = 1'b1; // [RULE23]
                                next_st.glob_bits = st.data[GLOB_MSB:GLOB_LSB]; // [RULE5]
                                next_st.glob_prior = st.lock; // [RULE5]
                            end
                        end
                    end
                end
                OP_WRITE_STATUS2: begin
                    if (st.latch) begin // [RULE1]
                        next_st.latch = 1'b0; // [RULE10] [RULE12]
                        if (full_data && aligned) begin // [RULE12]
                            next_st.rst_en = st.data[RST_EN_BIT]; // [RULE9] [RULE10]
                            if (!st.frozen) begin // [RULE11]
                                next_st.lkdn_en = st.data[LKDN_EN_BIT]; // [RULE9]
                            end
                        end
                    end
                end
                OP_RESET: begin
                    // latch state is not consulted here
                    if (st.rst_en && full_data && aligned // [RULE13] [RULE14] [RULE18]
                            && st.data == RESET_CONFIRM) begin // [RULE15]
                        next_st.reset_pulse = 1'b1; // [RULE16]
                        next_st.rst_cnt = RST_W'(RST_TIME); // [RULE16]
                        next_st.latch = LATCH_RESET; // [RULE17]
                        next_st.psusp = 1'b0; // [RULE17]
                        next_st.esusp = 1'b0; // [RULE17]
                    end
                end
                default: begin
                end
            endcase
        end
        // set wins over a clear in the same cycle
        if (latch_set) begin
            next_st.latch = 1'b1;
        end
        if (program_suspend_set) begin
            next_st.psusp = 1'b1;
        end
        if (erase_suspend_set) begin
            next_st.esusp = 1'b1;
        end
        if (freeze_lockdown || st.frozen) begin
            next_st.frozen = 1'b1;
            next_st.lkdn_en = 1'b0; // [RULE21]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st <= '0;
            st.cs_s <= 3'h7;
            st.wp_s <= 2'h3;
            st.lock <= LOCK_RESET; // [RULE19]
            st.rst_en <= RST_EN_RESET; // [RULE20]
            st.lkdn_en <= LKDN_EN_RESET;
            st.latch <= LATCH_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign protect_regs_lock = st.lock;
    assign write_enable_latch = st.latch;
    assign reset_cmd_enable = st.rst_en;
    assign lockdown_cmd_enable = st.lkdn_en;
    assign lockdown_frozen = st.frozen;
    assign program_suspend_flag = st.psusp;
    assign erase_suspend_flag = st.esusp;
    assign glob_valid = st.glob_valid;
    assign glob_bits = st.glob_bits;
    assign glob_prior_lock = st.glob_prior;
    assign reset_pulse = st.reset_pulse;
    assign in_reset = (st.rst_cnt != '0);
endmodule

//--- fsr_host.sv
`timescale 1ns/10ps
module fsr_host (
    input wire logic core_clk,
    input wire logic reset_n,
    fsr_if.host link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import fsr_pkg::*;

    typedef enum logic [2:0] {H_IDLE, H_LOW, H_HIGH, H_TAIL, H_GAP} fsr_host_e;

    typedef struct packed {
        fsr_host_e state;
        logic [2:0] div;
        logic [31:0] payload;
        logic [31:0] shreg;
        logic [5:0] bits_left;
        logic cs_n;
        logic sck;
        logic [31:0] rdata;
        logic err;
    } fsr_host_s;

    fsr_host_s st;
    fsr_host_s next_st;
    logic tick;
    logic setup;
    logic busy;

    assign tick = (st.div == 3'(SCK_HALF_CYCLES - 1));
    assign setup = psel & ~penable;
    assign busy = (st.state != H_IDLE);

    always_comb begin
        next_st = st;
        next_st.div = tick ? 3'h0 : st.div + 3'h1;
        if (setup) begin
            next_st.err = !(paddr == HOST_CTRL || paddr == HOST_DATA || paddr == HOST_STATUS);
            next_st.rdata = 32'h0;
            if (paddr == HOST_DATA) begin
                next_st.rdata = st.payload;
            end
            if (paddr == HOST_STATUS) begin
                next_st.rdata = {31'h0, busy};
            end
        end
        if (psel && penable && pwrite && paddr == HOST_DATA) begin
            next_st.payload = pwdata;
        end
        unique case (st.state)
            H_IDLE: begin
                // a start while busy is dropped; a bit count of zero does nothing
                if (psel && penable && pwrite && paddr == HOST_CTRL && pwdata[5:0] != 6'h0) begin
                    next_st.bits_left = pwdata[5:0];
                    next_st.shreg = st.payload; // [RULE2] [RULE8] [RULE15]
                    next_st.cs_n = 1'b0;
                    next_st.div = 3'h0;
                    next_st.state = H_LOW;
                end
            end
            H_LOW: begin
                if (tick) begin
                    next_st.sck = 1'b1; // [RULE24]
                    next_st.state = H_HIGH;
                end
            end
            H_HIGH: begin
                if (tick) begin
                    next_st.sck = 1'b0;
                    next_st.bits_left = st.bits_left - 6'h1;
                    next_st.shreg = {st.shreg[30:0], 1'b0}; // [RULE24]
                    next_st.state = (st.bits_left == 6'h1) ? H_TAIL : H_LOW;
                end
            end
            H_TAIL: begin
                if (tick) begin
                    next_st.cs_n = 1'b1;
                    next_st.state = H_GAP;
                end
            end
            H_GAP: begin
                if (tick) begin
                    next_st.state = H_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st <= '0;
            st.state <= H_IDLE;
            st.cs_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // the write latch is set through the device's latch_set input, not by this host, before status writes
    assign link.cs_n = st.cs_n; // [RULE1]
    assign link.sck = st.sck;
    assign link.mosi = st.shreg[31];
    assign prdata = st.rdata;
    assign pready = 1'b1;
    assign pslverr = psel & penable & st.err;
endmodule

//--- fsr_if.sv
`timescale 1ns/10ps
interface fsr_if;
    logic cs_n;
    logic sck;
    logic mosi;
    modport host (output cs_n, output sck, output mosi);
    modport dev (input cs_n, input sck, input mosi);
endinterface

//--- fsr_pkg.sv
package fsr_pkg;
    localparam logic [7:0] OP_WRITE_STATUS1 = 8'h01;
    localparam logic [7:0] OP_WRITE_STATUS2 = 8'h31;
    localparam logic [7:0] OP_RESET = 8'hF0;
    localparam logic [7:0] RESET_CONFIRM = 8'hD0;
    // data byte field positions
    localparam int LOCK_BIT = 7;
    localparam int GLOB_MSB = 5;
    localparam int GLOB_LSB = 2;
    localparam int RST_EN_BIT = 4;
    localparam int LKDN_EN_BIT = 3;
    // power-up values
    localparam logic LOCK_RESET = 1'b0;
    localparam logic RST_EN_RESET = 1'b0;
    localparam logic LKDN_EN_RESET = 1'b0;
    localparam logic LATCH_RESET = 1'b0;
    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int SCK_PERIOD_NS = 160;
    localparam int SCK_HALF_CYCLES = SCK_PERIOD_NS / 2 / CLK_PERIOD_NS;
    localparam int T_RST_NS = 1000;
    localparam int RST_CYCLES = T_RST_NS / CLK_PERIOD_NS;
    localparam int RST_W = 16;
    // host register map, byte addresses
    localparam logic [7:0] HOST_CTRL = 8'h00;
    localparam logic [7:0] HOST_DATA = 8'h04;
    localparam logic [7:0] HOST_STATUS = 8'h08;
endpackage

//--- tb.sv
`timescale 1ns/10ps
module tb;
    import fsr_pkg::*;
    logic core_clk, reset_n, wp_n, psel, penable, pwrite, pready, pslverr, er, p, fr;
    logic lk, wl, re, le, fz, psf, esf, gv, rp, ir, gp;
    logic [7:0] paddr, b;
    logic [31:0] pwdata, prdata, r, rnd, sh, nb;
    logic [3:0] pv, gb;
    logic [4:0] g;
    logic [5:0] m;
    int n_mismatch = 0;
    int cmp_count = 0;
    fsr_if bus ();
    fsr_host u_fsr_host (.core_clk(core_clk), .reset_n(reset_n), .link(bus.host), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    fsr_dev #(.RST_TIME(4)) u_fsr_dev (.core_clk(core_clk), .reset_n(reset_n), .link(bus.dev),
        .wp_n(wp_n), .latch_set(pv[3]), .freeze_lockdown(pv[2]), .program_suspend_set(pv[1]),
        .erase_suspend_set(pv[0]), .protect_regs_lock(lk), .write_enable_latch(wl),
        .reset_cmd_enable(re), .lockdown_cmd_enable(le), .lockdown_frozen(fz),
        .program_suspend_flag(psf), .erase_suspend_flag(esf), .glob_valid(gv), .glob_bits(gb),
        .glob_prior_lock(gp), .reset_pulse(rp), .in_reset(ir));
    fsr_checker u_fsr_checker (.core_clk(core_clk), .reset_n(reset_n), .cs_n(bus.cs_n),
        .sck(bus.sck), .mosi(bus.mosi), .protect_regs_lock(lk), .write_enable_latch(wl),
        .reset_cmd_enable(re), .lockdown_cmd_enable(le), .lockdown_frozen(fz),
        .program_suspend_flag(psf), .erase_suspend_flag(esf), .glob_valid(gv),
        .reset_pulse(rp), .in_reset(ir));
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    always @(negedge bus.cs_n) begin
        nb = '0;
        sh = '0;
    end
    always @(posedge bus.sck) begin
        if (!bus.cs_n) begin
            sh = {sh[30:0], bus.mosi};
            nb = nb + 32'h1;
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // model bits: 5 lock, 4 latch, 3 reset enable, 2 lockdown enable, 1/0 suspends
    function automatic logic [5:0] wr1(input logic [5:0] s, input logic [7:0] d);
        s[5] = (!wp_n && !d[LOCK_BIT]) ? s[5] : d[LOCK_BIT];
        s[4] = 1'b0;
        return s;
    endfunction
    function automatic logic [5:0] wr2(input logic [5:0] s, input logic [7:0] d);
        s[3] = d[RST_EN_BIT];
        s[2] = fr ? 1'b0 : d[LKDN_EN_BIT];
        s[4] = 1'b0;
        return s;
    endfunction
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cst(input string nm);
        repeat (2) @(posedge core_clk);
        chk(nm, {26'h0, lk, wl, re, le, psf, esf}, {26'h0, m});
        $display("test %s done", nm);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            n_mismatch++;
            wrap_up();
        end
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic frame(input logic [31:0] d, input int n);
        int k;
        apb(1'b1, HOST_DATA, d);
        apb(1'b1, HOST_CTRL, 32'(n));
        k = 0;
        do begin
            apb(1'b0, HOST_STATUS, 32'h0);
            k++;
        end while (r[0] !== 1'b0 && k < 200);
        if (k >= 200) begin
            n_mismatch++;
            wrap_up();
        end
        repeat (4) @(posedge core_clk);
        chk("bit count", nb, 32'(n));
        chk("wire bits", sh, d >> (32 - n));
    endtask
    task automatic pls(input logic [3:0] v);
        pv <= v;
        @(posedge core_clk);
        pv <= 4'h0;
        @(posedge core_clk);
    endtask
    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata, pv, fr} = '0;
        wp_n = 1'b1;
        rnd = 32'h0001150B;
        m = '0;
        g = '0;
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        cst("power_up");
        apb(1'b0, 8'h0C, 32'h0);
        chk("slverr", {31'h0, er}, 32'h1);
        chk("rdata", r, 32'h0);
        frame(32'h0180_0000, 16);
        cst("no_latch");
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            wp_n <= (i < 6) ? rnd[9] : 1'b0;
            b = (i == 6) ? 8'h80 : (i == 7) ? 8'h00 : rnd[7:0];
            pls(4'h8);
            frame({OP_WRITE_STATUS1, b, rnd[23:8]}, rnd[8] ? 24 : 16);
            if (wp_n || b[LOCK_BIT]) g = {b[GLOB_MSB:GLOB_LSB], m[5]};
            m = wr1(m, b);
            cst("status1");
            chk("glob", {27'h0, gb, gp}, {27'h0, g});
        end
        wp_n <= 1'b1;
        pls(4'h8);
        frame(32'h0100_0000, 12);
        cst("status1_misaligned");
        pls(4'h8);
        m[4] = 1'b1;
        frame(32'h0100_0000, 5);
        cst("short_opcode");
        frame(32'h31FF_0000, 16);
        m = wr2(m, 8'hFF);
        cst("status2");
        pls(4'h8);
        frame(32'h3100_0000, 12);
        cst("status2_short");
        pls(4'hB);
        m[4:0] = m[4:0] | 5'h13;
        frame(32'hF0D1_0000, 16);
        frame(32'hF0D0_0000, 20);
        cst("reset_bad");
        frame({OP_RESET, RESET_CONFIRM, rnd[15:0]}, 24);
        m[4:0] = m[4:0] & 5'h0C;
        cst("reset_run");
        pls(4'h4);
        fr = 1'b1;
        m[2] = 1'b0;
        cst("freeze");
        pls(4'h8);
        frame(32'h3108_0000, 16);
        m = wr2(m, 8'h08);
        cst("frozen_write");
        pls(4'hB);
        m[4:0] = m[4:0] | 5'h13;
        frame(32'hF0D0_0000, 16);
        cst("reset_disabled");
        wrap_up();
    end
    initial begin
        repeat (90000) @(posedge core_clk);
        n_mismatch++;
        wrap_up();
    end
endmodule
